// [logic/sclkg_top.v]
`timescale 1ns/100ps
`include "sclkg_defs.vh"
module sclkg_top (
   // clock and reset
   input wire clk_sys,
   input wire nrst,
   // axi4-lite write address
   input wire [3:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [3:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // axi4-lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // transfer clock pin
   input wire transfer_clock_pin_i,
   output wire transfer_clock_pin_o,
   output wire transfer_clock_pin_oe,
   // base clocks, recovery states and clock mode to transmitter and receiver
   output wire txclk_en,
   output wire rxclk_en,
   output wire sync_change_en,
   output wire sync_sample_en,
   output wire [4:0] recovery_states,
   output wire [1:0] clock_mode
);

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   reg sync_mode_select_r;
   reg double_speed_bit_r;
   reg xfer_clock_pin_direction_r;
   reg sync_clock_polarity_r;
   reg port_power_off_r;
   reg [7:0] baud_divisor_low_r;
   reg [3:0] baud_divisor_high_r;
   wire [11:0] baud_divisor;
   wire [4:0] ctrl_rst;

   assign ctrl_rst = `SCLKG_CTRL_RST;

   // ----------------------------------------------------------------
   // bus state
   // ----------------------------------------------------------------
   reg aw_held_r;
   reg [3:0] aw_addr_r;
   reg w_held_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   reg bvalid_r;
   reg [1:0] bresp_r;
   reg rvalid_r;
   reg [31:0] rdata_r;
   reg [1:0] rresp_r;
   wire aw_take;
   wire w_take;
   wire wr_fire;
   wire ar_take;
   wire wr_low;
   wire lane0;
   reg wr_hit;
   reg rd_hit;
   reg [31:0] rd_word;

   // ----------------------------------------------------------------
   // clock generation state
   // ----------------------------------------------------------------
   reg [11:0] baud_cnt_r;
   reg master_lvl_r;
   reg [1:0] mode;
   wire active;
   wire is_sync;
   wire is_master;
   wire is_slave;
   wire baud_tick;
   wire ext_level;
   wire ext_rise;
   wire ext_fall;
   wire m_rise;
   wire m_fall;
   wire sync_rise;
   wire sync_fall;
   wire async_tx_tick;
   reg [3:0] tx_limit;
   reg [4:0] states;

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   assign active = ~port_power_off_r;
   assign is_sync = sync_mode_select_r;
   assign is_master = is_sync & xfer_clock_pin_direction_r;
   assign is_slave = is_sync & ~xfer_clock_pin_direction_r;
   assign baud_divisor = {baud_divisor_high_r, baud_divisor_low_r};

   always @* begin
      mode = `SCLKG_MODE_NORM;
      if (is_master) begin
         mode = `SCLKG_MODE_MST;
      end else if (is_slave) begin
         mode = `SCLKG_MODE_SLV;
      end else if (double_speed_bit_r) begin
         mode = `SCLKG_MODE_DBL;
      end
   end

   always @* begin
      case (mode)
         `SCLKG_MODE_NORM: begin
            tx_limit = `SCLKG_LIM_NORM;
            states = `SCLKG_STATES_NORM;
         end
         `SCLKG_MODE_DBL: begin
            tx_limit = `SCLKG_LIM_DBL;
            states = `SCLKG_STATES_DBL;
         end
         `SCLKG_MODE_MST: begin
            tx_limit = `SCLKG_LIM_MST;
            states = `SCLKG_STATES_SYNC;
         end
         default: begin
            tx_limit = `SCLKG_LIM_MST;
            states = `SCLKG_STATES_SYNC;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // baud rate down-counter
   // ----------------------------------------------------------------
   // reload on low-byte write takes priority over the zero reload
   assign baud_tick = active && !wr_low && (baud_cnt_r == 12'h000) && !is_slave;

   always @(posedge clk_sys) begin
      if (!nrst || !active) begin
         baud_cnt_r <= 12'h000;
      end else if (wr_low) begin
         baud_cnt_r <= {baud_divisor_high_r, w_data_r[7:0]};
      end else if (baud_cnt_r == 12'h000) begin
         baud_cnt_r <= baud_divisor;
      end else begin
         baud_cnt_r <= baud_cnt_r - 12'h001;
      end
   end

   // ----------------------------------------------------------------
   // transmit divider for asynchronous modes
   // ----------------------------------------------------------------
   sclkg_tick_div u_tx_div (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .clear(!active || is_sync),
      .limit(tx_limit),
      .tick_in(baud_tick),
      .tick_out(async_tx_tick)
   );

   // ----------------------------------------------------------------
   // master clock output: one half period per baud tick
   // ----------------------------------------------------------------
   // idle level follows polarity so the first edge is a change edge, unless the write selecting master also changes polarity
   always @(posedge clk_sys) begin
      if (!nrst) begin
         master_lvl_r <= 1'b0;
      end else if (!active || !is_master) begin
         master_lvl_r <= sync_clock_polarity_r;
      end else if (baud_tick) begin
         master_lvl_r <= ~master_lvl_r;
      end
   end

   assign m_rise = is_master & baud_tick & ~master_lvl_r;
   assign m_fall = is_master & baud_tick & master_lvl_r;
   assign transfer_clock_pin_o = master_lvl_r;
   assign transfer_clock_pin_oe = active & is_master;

   // ----------------------------------------------------------------
   // external clock for slave mode
   // ----------------------------------------------------------------
   // chain held clear outside slave mode, so the pin is not sampled
   sclkg_edge_sync u_ext_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .clear(!active || !is_slave),
      .pin_i(transfer_clock_pin_i),
      .level(ext_level),
      .rise(ext_rise),
      .fall(ext_fall)
   );

   // ----------------------------------------------------------------
   // edge selection and base clocks
   // ----------------------------------------------------------------
   assign sync_rise = (is_slave & active & ext_rise) | m_rise;
   assign sync_fall = (is_slave & active & ext_fall) | m_fall;
   assign sync_change_en = sync_clock_polarity_r ? sync_fall : sync_rise;
   assign sync_sample_en = sync_clock_polarity_r ? sync_rise : sync_fall;
   assign txclk_en = is_sync ? sync_change_en : async_tx_tick;
   assign rxclk_en = is_sync ? sync_sample_en : baud_tick;
   assign recovery_states = states;
   assign clock_mode = mode;

   // ----------------------------------------------------------------
   // axi4-lite write path
   // ----------------------------------------------------------------
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
   assign lane0 = w_strb_r[0];
   assign wr_low = wr_fire && (aw_addr_r == `SCLKG_ADDR_DIVL) && lane0;

   always @* begin
      case (aw_addr_r)
         `SCLKG_ADDR_CTRL: wr_hit = 1'b1;
         `SCLKG_ADDR_DIVL: wr_hit = 1'b1;
         `SCLKG_ADDR_DIVH: wr_hit = 1'b1;
         `SCLKG_ADDR_STAT: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always @(posedge clk_sys) begin
      if (!nrst) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 4'h0;
         w_held_r <= 1'b0;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= `SCLKG_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[3:2], 2'b00};
         end
         if (w_take) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? `SCLKG_RESP_OKAY : `SCLKG_RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   // status word is read only; writes to it are accepted and dropped
   always @(posedge clk_sys) begin
      if (!nrst) begin
         sync_mode_select_r <= ctrl_rst[`SCLKG_CTRL_SYNC];
         double_speed_bit_r <= ctrl_rst[`SCLKG_CTRL_DBL];
         xfer_clock_pin_direction_r <= ctrl_rst[`SCLKG_CTRL_DIR];
         sync_clock_polarity_r <= ctrl_rst[`SCLKG_CTRL_POL];
         port_power_off_r <= ctrl_rst[`SCLKG_CTRL_POFF];
         baud_divisor_low_r <= 8'h00;
         baud_divisor_high_r <= 4'h0;
      end else if (wr_fire && lane0) begin
         case (aw_addr_r)
            `SCLKG_ADDR_CTRL: begin
               sync_mode_select_r <= w_data_r[`SCLKG_CTRL_SYNC];
               double_speed_bit_r <= w_data_r[`SCLKG_CTRL_DBL];
               xfer_clock_pin_direction_r <= w_data_r[`SCLKG_CTRL_DIR];
               sync_clock_polarity_r <= w_data_r[`SCLKG_CTRL_POL];
               port_power_off_r <= w_data_r[`SCLKG_CTRL_POFF];
            end
            `SCLKG_ADDR_DIVL: begin
               baud_divisor_low_r <= w_data_r[7:0];
            end
            `SCLKG_ADDR_DIVH: begin
               baud_divisor_high_r <= w_data_r[3:0];
            end
            default: begin
               baud_divisor_high_r <= baud_divisor_high_r;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read path
   // ----------------------------------------------------------------
   assign s_axi_arready = !rvalid_r;
   assign ar_take = s_axi_arvalid && s_axi_arready;

   always @* begin
      rd_hit = 1'b1;
      rd_word = 32'h00000000;
      case ({s_axi_araddr[3:2], 2'b00})
         `SCLKG_ADDR_CTRL: begin
            rd_word[`SCLKG_CTRL_SYNC] = sync_mode_select_r;
            rd_word[`SCLKG_CTRL_DBL] = double_speed_bit_r;
            rd_word[`SCLKG_CTRL_DIR] = xfer_clock_pin_direction_r;
            rd_word[`SCLKG_CTRL_POL] = sync_clock_polarity_r;
            rd_word[`SCLKG_CTRL_POFF] = port_power_off_r;
         end
         `SCLKG_ADDR_DIVL: begin
            rd_word[7:0] = baud_divisor_low_r;
         end
         `SCLKG_ADDR_DIVH: begin
            rd_word[3:0] = baud_divisor_high_r;
         end
         `SCLKG_ADDR_STAT: begin
            rd_word[`SCLKG_STAT_CNT_LSB +: 12] = baud_cnt_r;
            rd_word[`SCLKG_STAT_LVL] = is_master ? master_lvl_r : ext_level;
            rd_word[`SCLKG_STAT_MODE_LSB +: 2] = mode;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (!nrst) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= `SCLKG_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= rd_hit ? `SCLKG_RESP_OKAY : `SCLKG_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

endmodule // sclkg_top

// [logic/sclkg_defs.vh]
`ifndef SCLKG_DEFS_VH
`define SCLKG_DEFS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define SCLKG_ADDR_CTRL 4'h0
`define SCLKG_ADDR_DIVL 4'h4
`define SCLKG_ADDR_DIVH 4'h8
`define SCLKG_ADDR_STAT 4'hC

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define SCLKG_CTRL_SYNC 0
`define SCLKG_CTRL_DBL 1
`define SCLKG_CTRL_DIR 2
`define SCLKG_CTRL_POL 3
`define SCLKG_CTRL_POFF 4
`define SCLKG_CTRL_RST 5'h10

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define SCLKG_STAT_CNT_LSB 0
`define SCLKG_STAT_LVL 16
`define SCLKG_STAT_MODE_LSB 20

// ----------------------------------------------------------------
// clock modes and divide limits (count minus one)
// ----------------------------------------------------------------
`define SCLKG_MODE_NORM 2'h0
`define SCLKG_MODE_DBL 2'h1
`define SCLKG_MODE_MST 2'h2
`define SCLKG_MODE_SLV 2'h3
`define SCLKG_LIM_NORM 4'hF
`define SCLKG_LIM_DBL 4'h7
`define SCLKG_LIM_MST 4'h1
`define SCLKG_STATES_NORM 5'h10
`define SCLKG_STATES_DBL 5'h08
`define SCLKG_STATES_SYNC 5'h02
`define SCLKG_SYNC_FILL 2'h3

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define SCLKG_RESP_OKAY 2'h0
`define SCLKG_RESP_SLVERR 2'h2

`endif

// [logic/sclkg_edge_sync.v]
`timescale 1ns/100ps
`include "sclkg_defs.vh"
module sclkg_edge_sync (
   // clock and reset
   input wire clk_sys,
   input wire nrst,
   // clear while unused
   input wire clear,
   // asynchronous pin in
   input wire pin_i,
   // synchronised level and edges
   output wire level,
   output wire rise,
   output wire fall
);
   reg meta_r;
   reg sync_r;
   reg prev_r;
   reg [1:0] fill_r;
   wire primed;

   always @(posedge clk_sys) begin
      if (!nrst || clear) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
         fill_r <= 2'h0;
      end else begin
         meta_r <= pin_i;
         sync_r <= meta_r;
         prev_r <= sync_r;
         if (!primed) begin
            fill_r <= fill_r + 2'h1;
         end
      end
   end

   // no edges until prev_r holds a real pin sample; an idle-high pin
   // would otherwise show a false rise after clear
   assign primed = (fill_r == `SCLKG_SYNC_FILL);
   assign level = sync_r;
   assign rise = primed & sync_r & ~prev_r;
   assign fall = primed & ~sync_r & prev_r;
endmodule // sclkg_edge_sync

// [logic/sclkg_tick_div.v]
`timescale 1ns/100ps
module sclkg_tick_div (
   // clock and reset
   input wire clk_sys,
   input wire nrst,
   // control
   input wire clear,
   input wire [3:0] limit,
   // ticks
   input wire tick_in,
   output wire tick_out
);
   reg [3:0] cnt_r;
   wire wrap;

   assign wrap = tick_in && (cnt_r >= limit);
   assign tick_out = wrap;

   always @(posedge clk_sys) begin
      if (!nrst || clear) begin
         cnt_r <= 4'h0;
      end else if (wrap) begin
         cnt_r <= 4'h0;
      end else if (tick_in) begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule // sclkg_tick_div

// [sim/sclkg_peer.sv]
`timescale 1ns/100ps
module sclkg_peer #(
   parameter HALF_NS = 333,
   parameter PERIODS = 4
) (
   // idle timing
   input wire clk_sys,
   // control from bench
   input wire en,
   input wire go,
   input wire pol,
   // line level
   output reg lvl
);
initial begin
   lvl = 1'b0;
   forever begin
      @(negedge clk_sys);
      if (!en) begin
         lvl = ~lvl; // released: keep it moving
      end else if (go) begin
         repeat (2 * PERIODS) #HALF_NS lvl = ~lvl;
      end else begin
         lvl = pol;
      end
   end
end
endmodule // sclkg_peer

// [sim/sclkg_monitor.sv]
`timescale 1ns/100ps
module sclkg_monitor (
   // clock and reset
   input wire clk_sys,
   input wire nrst,
   // pin
   input wire transfer_clock_pin_i,
   input wire transfer_clock_pin_oe,
   // base clocks
   input wire txclk_en,
   input wire rxclk_en,
   input wire sync_change_en,
   input wire sync_sample_en,
   input wire [4:0] recovery_states,
   input wire [1:0] clock_mode
);
default clocking cb @(posedge clk_sys); endclocking
default disable iff (!nrst);
chk_pin_async_off: assert property (!clock_mode[1] |-> !transfer_clock_pin_oe)
   else $error("pin driven in async mode");
chk_oe_master_only: assert property (transfer_clock_pin_oe |-> clock_mode == 2'h2)
   else $error("pin driven outside master mode");
chk_states_mode: assert property (recovery_states == (clock_mode == 2'h0 ? 5'h10 :
   (clock_mode == 2'h1 ? 5'h08 : 5'h02))) else $error("recovery states wrong");
chk_tx_on_tick: assert property (!clock_mode[1] && txclk_en |-> rxclk_en)
   else $error("tx clock off baud tick");
chk_master_tx: assert property (clock_mode == 2'h2 |-> txclk_en == sync_change_en)
   else $error("master tx clock not change edge");
chk_sync_rx: assert property (clock_mode[1] |-> rxclk_en == sync_sample_en)
   else $error("sync rx clock not sample edge");
chk_edges_apart: assert property (!(sync_change_en && sync_sample_en))
   else $error("change and sample together");
chk_sync_only: assert property (sync_change_en || sync_sample_en |-> clock_mode[1])
   else $error("sync edge in async mode");
chk_slave_lat: assert property (clock_mode == 2'h3 && $past(clock_mode) == 2'h3
   && $changed(transfer_clock_pin_i) |-> ##2 (sync_change_en || sync_sample_en))
   else $error("slave edge missed");
chk_reset_quiet: assert property ($rose(nrst) |-> !txclk_en && !rxclk_en
   && !transfer_clock_pin_oe && clock_mode == 2'h0) else $error("activity after reset");
endmodule // sclkg_monitor
bind sclkg_top sclkg_monitor mon (.clk_sys(clk_sys), .nrst(nrst),
   .transfer_clock_pin_i(transfer_clock_pin_i), .transfer_clock_pin_oe(transfer_clock_pin_oe),
   .txclk_en(txclk_en), .rxclk_en(rxclk_en), .sync_change_en(sync_change_en),
   .sync_sample_en(sync_sample_en), .recovery_states(recovery_states),
   .clock_mode(clock_mode));

// [sim/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
reg clk_sys = 1'b0;
reg nrst = 1'b0;
reg [3:0] s_axi_awaddr = 4'h0;
reg [3:0] s_axi_araddr = 4'h0;
reg [31:0] s_axi_wdata = 32'h0;
reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
reg peer_en = 1'b0, peer_go = 1'b0, peer_pol = 1'b0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp, clock_mode;
wire [31:0] s_axi_rdata;
wire [4:0] recovery_states;
wire pin_i, pin_o, pin_oe, txclk_en, rxclk_en, chg_en, smp_en, peer_lvl;
integer n_fail = 0;
integer checked = 0;
localparam [19:0] T_CTL = {5'h07, 5'h05, 5'h02, 5'h00};
localparam [31:0] T_DIV = {8'h02, 8'h02, 8'h08, 8'h10};
localparam [19:0] T_RS = {5'h02, 5'h02, 5'h08, 5'h10};
localparam [7:0] T_MD = {2'h2, 2'h2, 2'h1, 2'h0};
always #50 clk_sys = ~clk_sys;
assign pin_i = pin_oe ? pin_o : peer_lvl;
sclkg_top dut (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .transfer_clock_pin_i(pin_i), .transfer_clock_pin_o(pin_o),
   .transfer_clock_pin_oe(pin_oe), .txclk_en(txclk_en), .rxclk_en(rxclk_en),
   .sync_change_en(chg_en), .sync_sample_en(smp_en), .recovery_states(recovery_states),
   .clock_mode(clock_mode));
sclkg_peer peer (.clk_sys(clk_sys), .en(peer_en), .go(peer_go), .pol(peer_pol),
   .lvl(peer_lvl));
task final_report;
   begin
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   end
endtask
task give_up;
   begin
      n_fail = n_fail + 1;
      $display("BAD %0t wait limit reached", $time);
      final_report;
   end
endtask
task check(input [31:0] seen, input [31:0] exp);
   begin
      checked = checked + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   end
endtask
task axi_write(input [3:0] a, input [31:0] d);
   integer n;
   reg done;
   begin
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 50 && !done; n = n + 1) begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         done = s_axi_bvalid;
      end
      s_axi_bready <= 1'b0;
      if (!done) give_up;
      else check(s_axi_bresp, 2'h0);
   end
endtask
task axi_read(input [3:0] a, output [31:0] d);
   integer n;
   reg done;
   begin
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      done = 1'b0;
      d = 32'h0;
      for (n = 0; n < 50 && !done; n = n + 1) begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         done = s_axi_rvalid;
         d = s_axi_rdata;
      end
      s_axi_rready <= 1'b0;
      if (!done) give_up;
      else check(s_axi_rresp, 2'h0);
   end
endtask
function pick(input integer w);
   pick = w == 0 ? txclk_en : (w == 1 ? rxclk_en : (w == 2 ? chg_en : smp_en));
endfunction
// edges until the chosen pulse is seen
task wait_pulse(input integer w, output integer n);
   begin
      n = 1;
      @(posedge clk_sys);
      while (pick(w) !== 1'b1 && n < 5000) begin
         @(posedge clk_sys);
         n = n + 1;
      end
      if (n >= 5000) give_up;
   end
endtask
task count_pulses(input integer cyc, output integer nt, output integer nr, output integer nc,
   output integer ns, output integer first);
   integer i;
   begin
      {nt, nr, nc, ns, first} = 0;
      for (i = 0; i < cyc; i = i + 1) begin
         @(posedge clk_sys);
         if (nc + ns == 0 && chg_en) first = 1;
         nt = nt + txclk_en;
         nr = nr + rxclk_en;
         nc = nc + chg_en;
         ns = ns + smp_en;
      end
   end
endtask
task t_reset;
   integer nt, nr, nc, ns, f;
   reg [31:0] d;
   begin
      count_pulses(100, nt, nr, nc, ns, f);
      check(nt + nr + nc + ns, 0);
      check(recovery_states, 5'h10);
      axi_read(4'h0, d);
      check(d, 32'h10);
      $display("t_reset done");
   end
endtask
task t_modes;
   integer i, n;
   reg [31:0] d;
   begin
      axi_write(4'h8, 32'h1);
      axi_write(4'h4, 32'h2);
      for (i = 0; i < 4; i = i + 1) begin
         axi_write(4'h0, T_CTL[i*5 +: 5]);
         wait_pulse(0, n);
         wait_pulse(0, n);
         check(n, 259 * T_DIV[i*8 +: 8]);
         if (i < 2) begin
            wait_pulse(1, n);
            wait_pulse(1, n);
            check(n, 259);
         end
         check(recovery_states, T_RS[i*5 +: 5]);
         check(clock_mode, T_MD[i*2 +: 2]);
         check(pin_oe, i > 1);
         axi_read(4'hC, d);
         check(d[21:20], T_MD[i*2 +: 2]);
      end
      $display("t_modes done");
   end
endtask
task t_reload;
   integer n;
   begin
      axi_write(4'h0, 32'h0);
      wait_pulse(1, n);
      repeat (30) @(posedge clk_sys);
      axi_write(4'h4, 32'h5);
      wait_pulse(1, n);
      check(n, 12'h105);
      $display("t_reload done");
   end
endtask
task t_master;
   integer p, n;
   begin
      for (p = 0; p < 2; p = p + 1) begin
         axi_write(4'h0, 32'h5 | (p << 3));
         wait_pulse(2, n);
         #1;
         check(pin_o, !p[0]);
         wait_pulse(3, n);
         #1;
         check(pin_o, p[0]);
      end
      $display("t_master done");
   end
endtask
task t_slave;
   integer p, nt, nr, nc, ns, f;
   begin
      for (p = 0; p < 2; p = p + 1) begin
         axi_write(4'h0, 32'h0);
         peer_en <= 1'b1;
         peer_pol <= p[0];
         axi_write(4'h0, 32'h1 | (p << 3));
         count_pulses(10, nt, nr, nc, ns, f);
         check(nc + ns, 0);
         check(pin_oe, 1'b0);
         peer_go <= 1'b1;
         @(posedge clk_sys);
         peer_go <= 1'b0;
         count_pulses(40, nt, nr, nc, ns, f);
         check(nc, 4);
         check(ns, 4);
         check(nt, 4);
         check(f, 1);
      end
      $display("t_slave done");
   end
endtask
task t_power;
   integer nt, nr, nc, ns, f;
   begin
      axi_write(4'h0, 32'h15);
      peer_en <= 1'b0;
      count_pulses(200, nt, nr, nc, ns, f);
      check(nt + nr + nc + ns, 0);
      check(pin_oe, 1'b0);
      $display("t_power done");
   end
endtask
initial begin
   repeat (4) @(posedge clk_sys);
   nrst <= 1'b1;
   t_reset;
   t_modes;
   t_reload;
   t_master;
   t_slave;
   t_power;
   final_report;
end
endmodule // tb_top
